// file: logic/srcd_clkdiv.v
/*
 * crystal divider: makes one-cycle tick enables for the system and
 * timer clocks from the crystal-rate clk, with a divide-by-two or
 * divide-by-one base and an optional divide-by-16 prescaler.
 * assumes clk is the crystal input and rst is synchronous, high.
 */
`timescale 1ns/1ps
`include "srcd_regs.vh"

module srcd_clkdiv (
   // clock and reset
   input  wire clk,
   input  wire rst,
   // settings
   input  wire crystal_input_undivided,
   input  wire div16_en,
   // gates
   input  wire sys_run,
   input  wire tmr_run,
   // ticks
   output wire sys_tick,
   output wire timer_tick
);

   reg       half_q;
   reg [3:0] pre_q;
   reg       sys_q;
   reg       tmr_q;
   wire      base;
   wire      tick;

   // ****************************************
   // base divider and prescaler
   // ****************************************
   assign base = crystal_input_undivided | half_q;
   assign tick = base & (~div16_en | (pre_q == `SRCD_PRE_LAST));

   always @(posedge clk) begin
      if (rst) begin
         half_q <= 1'b0;
         pre_q  <= `SRCD_PRE_RST;
         sys_q  <= 1'b0;
         tmr_q  <= 1'b0;
      end else begin
         half_q <= ~half_q;
         if (base) begin
            pre_q <= pre_q + 4'h1;
         end
         // sys tick stops in halt, timer tick keeps running
         sys_q <= tick & sys_run;
         tmr_q <= tick & tmr_run;
      end
   end

   assign sys_tick   = sys_q;
   assign timer_tick = tmr_q;

endmodule

// file: logic/srcd_regs.vh
/*
 * constants for the stop recovery and clock divider block: register
 * indexes, field positions, reset values and timing figures.
 * assumes inclusion by bare name from the design files.
 */
`ifndef SRCD_REGS_VH
`define SRCD_REGS_VH

// ****************************************
// register indexes (byte address = index * 4)
// ****************************************
`define SRCD_IDX_CTRL    6'h0b
`define SRCD_IDX_IRQ_ST  6'h0c
`define SRCD_IDX_IRQ_MSK 6'h0d
`define SRCD_IDX_STATE   6'h0e

// ****************************************
// control register fields
// ****************************************
`define SRCD_B_FLAG   7
`define SRCD_B_LEVEL  6
`define SRCD_B_DLY    5
`define SRCD_F_SRC_HI 4
`define SRCD_F_SRC_LO 2
`define SRCD_B_XDIV   1
`define SRCD_B_DIV16  0
`define SRCD_CTRL_RST 7'h00
`define SRCD_SRC_NONE 3'h0

// ****************************************
// interrupt status bits
// ****************************************
`define SRCD_IRQ_STOP 0
`define SRCD_IRQ_WAKE 1
`define SRCD_IRQ_W    2
`define SRCD_IRQ_RST  2'h0

// ****************************************
// restart and timing
// ****************************************
`define SRCD_VECTOR   16'h000c
`define SRCD_CLK_MHZ  20
`define SRCD_DLY_US   100
`define SRCD_DLY_W    12
`define SRCD_PRE_LAST 4'hf
`define SRCD_PRE_RST  4'h0

`endif

// file: logic/srcd_top.v
/*
 * stop recovery control and clock division, with an avalon-mm slave
 * for its registers and one level interrupt.
 * assumes one clock at crystal rate (20 MHz), rst as power-on reset,
 * wake pins asynchronous, core strobes on the same clock.
 */
// Our own choice: the Avalon-MM interface to the registers.
// What this block does
// - control register at index 0bh, write-only except bit 7
// - bit 6 picks wake level, low or high
// - bit 5 enables reset delay after recovery
// - bits 4:2 select the wake source
// - bit 1: 0 halves crystal, 1 undivided; reset 0
// - bit 0 adds divide-by-16 prescaler
// - prescaler slows system clock and halt timer clock
// - stop ends by reset source, restart at 000ch
`timescale 1ns/1ps
`include "srcd_regs.vh"

module srcd_top (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // avalon-mm slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [3:0]  avs_byteenable,
   input  wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // core state
   input  wire        stop_req,
   input  wire        halt_req,
   // wake sources
   input  wire [7:0]  wake_pin,
   input  wire        spi_match,
   input  wire        wdt_timeout,
   // core restart
   output wire        stopped,
   output wire        restart_pulse,
   output wire [15:0] restart_vector,
   // clock ticks
   output wire        sys_tick,
   output wire        timer_tick,
   // interrupt
   output wire        irq
);

   // ****************************************
   // states and derived timing
   // ****************************************
   localparam [3:0] ST_RUN  = 4'b0001;
   localparam [3:0] ST_STOP = 4'b0010;
   localparam [3:0] ST_DLY  = 4'b0100;
   localparam [3:0] ST_GO   = 4'b1000;

   localparam integer DLY_CYC_I = `SRCD_DLY_US * `SRCD_CLK_MHZ;
   localparam [`SRCD_DLY_W-1:0] DLY_CYC = DLY_CYC_I[`SRCD_DLY_W-1:0];
   localparam [`SRCD_DLY_W-1:0] DLY_ONE = {{(`SRCD_DLY_W-1){1'b0}}, 1'b1};
   // delay is a fixed 100 us of crystal clock, not programmable

   // ****************************************
   // register decode
   // ****************************************
   function hit;
      input [7:0] addr;
      input [5:0] idx;
      begin
         hit = (addr == {idx, 2'b00});
      end
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   reg  [6:0]             ctrl_q;
   reg                    flag_q;
   reg  [`SRCD_IRQ_W-1:0] irq_st_q;
   reg  [`SRCD_IRQ_W-1:0] irq_msk_q;
   reg  [3:0]             state_q;
   reg  [3:0]             state_d;
   reg  [`SRCD_DLY_W-1:0] dly_q;
   reg  [`SRCD_DLY_W-1:0] dly_d;
   reg                    ack_q;
   reg  [31:0]            rdata_q;
   reg  [31:0]            rdata_d;
   reg                    go_q;
   reg  [15:0]            vec_q;
   reg                    irq_q;
   reg  [7:0]             pin_s1_q;
   reg  [7:0]             pin_s2_q;
   wire                   req;
   wire                   wr_en;
   wire                   rd_en;
   wire [2:0]             src_sel;
   wire                   pin_wake;
   wire                   wake;
   wire                   ev_stop;
   wire                   ev_wake;
   wire [`SRCD_IRQ_W-1:0] ev_bits;
   wire [`SRCD_IRQ_W-1:0] clr_bits;

   // decoded state, strobes and fields
   wire                   in_run;
   wire                   in_stop;
   wire                   in_dly;
   wire                   in_go;
   wire                   wr_ctrl;
   wire                   wr_irq_st;
   wire                   wr_irq_msk;
   wire                   lvl_sel;
   wire                   dly_en;
   wire                   crystal_input_undiv;
   wire                   div16_sel;
   wire                   sys_run;
   wire                   tmr_run;
   wire [7:0]             ctrl_rd;
   wire [7:0]             state_rd;
   wire [7:0]             pin_lvl_ok;

   // ****************************************
   // wake pin synchronisers
   // ****************************************
   // pins are asynchronous; only the second stage is read below
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (rst) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= wake_pin[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
            end
         end
         // level compare after the second stage only
         assign pin_lvl_ok[gi] = (pin_s2_q[gi] == lvl_sel);
      end
   endgenerate

   // ****************************************
   // control fields
   // ****************************************
   assign lvl_sel    = ctrl_q[`SRCD_B_LEVEL];
   assign dly_en     = ctrl_q[`SRCD_B_DLY];
   assign crystal_input_undiv = ctrl_q[`SRCD_B_XDIV];
   assign div16_sel  = ctrl_q[`SRCD_B_DIV16];
   assign src_sel    = ctrl_q[`SRCD_F_SRC_HI:`SRCD_F_SRC_LO];

   // ****************************************
   // wake decision
   // ****************************************
   // source 0 means no pin wake, so a floating pin cannot end stop
   assign pin_wake = (src_sel != `SRCD_SRC_NONE) && pin_lvl_ok[src_sel];
   // spi wake is expected with the low level chosen by software
   assign wake     = pin_wake | spi_match | wdt_timeout;

   // ****************************************
   // stop state machine
   // ****************************************
   always @* begin
      state_d = state_q;
      dly_d   = dly_q;
      case (state_q)
         ST_RUN: begin
            if (stop_req) begin
               state_d = ST_STOP;
            end
         end
         ST_STOP: begin
            // only a reset source leaves stop
            if (wake) begin
               if (dly_en) begin
                  state_d = ST_DLY;
                  dly_d   = DLY_CYC;
               end else begin
                  state_d = ST_GO;
               end
            end
         end
         ST_DLY: begin
            if (dly_q <= DLY_ONE) begin
               state_d = ST_GO;
               dly_d   = {`SRCD_DLY_W{1'b0}};
            end else begin
               dly_d = dly_q - DLY_ONE;
            end
         end
         ST_GO: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
            dly_d   = {`SRCD_DLY_W{1'b0}};
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         state_q <= ST_RUN;
         dly_q   <= {`SRCD_DLY_W{1'b0}};
         go_q    <= 1'b0;
         vec_q   <= `SRCD_VECTOR;
      end else begin
         state_q <= state_d;
         dly_q   <= dly_d;
         go_q    <= in_go;
         vec_q   <= `SRCD_VECTOR;
      end
   end

   // ****************************************
   // state decode
   // ****************************************
   // decoded once; every consumer below reads these except state_rd, which reads state_q
   assign in_run  = (state_q == ST_RUN);
   assign in_stop = (state_q == ST_STOP);
   assign in_dly  = (state_q == ST_DLY);
   assign in_go   = (state_q == ST_GO);

   assign ev_stop = in_run & stop_req;
   assign ev_wake = in_go;

   // ****************************************
   // avalon-mm slave
   // ****************************************
   // one wait cycle per access keeps read data on a flip-flop
   assign req   = avs_read | avs_write;
   assign wr_en = avs_write & ~ack_q;
   assign rd_en = avs_read & ~ack_q;
   assign avs_waitrequest = req & ~ack_q;

   // lane 0 carries every register; the upper lanes are don't-care
   assign wr_ctrl    = wr_en & avs_byteenable[0] & hit(avs_address, `SRCD_IDX_CTRL);
   assign wr_irq_st  = wr_en & avs_byteenable[0] & hit(avs_address, `SRCD_IDX_IRQ_ST);
   assign wr_irq_msk = wr_en & avs_byteenable[0] & hit(avs_address, `SRCD_IDX_IRQ_MSK);

   // only the flag reads back; the rest is write-only
   assign ctrl_rd  = {flag_q, 7'h00};
   // one-hot state in the low nibble, halt level above it
   assign state_rd = {3'b000, halt_req, state_q};

   always @* begin
      rdata_d = 32'h0000_0000;
      if (hit(avs_address, `SRCD_IDX_CTRL)) begin
         rdata_d[7:0] = ctrl_rd;
      end else if (hit(avs_address, `SRCD_IDX_IRQ_ST)) begin
         rdata_d[`SRCD_IRQ_W-1:0] = irq_st_q;
      end else if (hit(avs_address, `SRCD_IDX_IRQ_MSK)) begin
         rdata_d[`SRCD_IRQ_W-1:0] = irq_msk_q;
      end else if (hit(avs_address, `SRCD_IDX_STATE)) begin
         rdata_d[7:0] = state_rd;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         if (rd_en) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign avs_readdata = rdata_q;

   // ****************************************
   // control register and recovery flag
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `SRCD_CTRL_RST;
         flag_q <= 1'b0;
      end else begin
         // bit 7 is not stored here, so a write cannot touch the flag
         if (wr_ctrl) begin
            ctrl_q <= avs_writedata[6:0];
         end
         if (ev_wake) begin
            flag_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // interrupt status and mask
   // ****************************************
   assign ev_bits[`SRCD_IRQ_STOP] = ev_stop;
   assign ev_bits[`SRCD_IRQ_WAKE] = ev_wake;
   assign clr_bits = wr_irq_st ? avs_writedata[`SRCD_IRQ_W-1:0] : `SRCD_IRQ_RST;

   always @(posedge clk) begin
      if (rst) begin
         irq_st_q  <= `SRCD_IRQ_RST;
         irq_msk_q <= `SRCD_IRQ_RST;
         irq_q     <= 1'b0;
      end else begin
         // a new event wins over a write-one clear in the same cycle
         irq_st_q <= (irq_st_q & ~clr_bits) | ev_bits;
         if (wr_irq_msk) begin
            irq_msk_q <= avs_writedata[`SRCD_IRQ_W-1:0];
         end
         // registered so a decode glitch never reaches the pin
         irq_q <= |(irq_st_q & irq_msk_q);
      end
   end

   assign irq = irq_q;

   // ****************************************
   // clock division
   // ****************************************
   // halt freezes only the system tick; stop and delay freeze both
   assign sys_run = in_run & ~halt_req;
   assign tmr_run = in_run;

   srcd_clkdiv u_div (
      .clk            (clk),
      .rst            (rst),
      .crystal_input_undivided (crystal_input_undiv),
      .div16_en       (div16_sel),
      .sys_run        (sys_run),
      .tmr_run        (tmr_run),
      .sys_tick       (sys_tick),
      .timer_tick     (timer_tick)
   );

   // ****************************************
   // core outputs
   // ****************************************
   // stopped covers the delay too, so the core stays frozen throughout
   assign stopped        = in_stop | in_dly;
   assign restart_pulse  = go_q;
   assign restart_vector = vec_q;

endmodule

// file: verif/srcd_top_asserts.sv
/* port checker for srcd_top.
   assumes it is bound onto srcd_top, one clock, rst synchronous high. */
`timescale 1ns/1ps
module srcd_chk (
   // clock and reset
   input wire        clk,
   input wire        rst,
   // bus
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   // core
   input wire        stop_req,
   input wire        halt_req,
   input wire        stopped,
   input wire        restart_pulse,
   input wire [15:0] restart_vector,
   input wire        sys_tick,
   input wire        timer_tick
);
   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest;
   endsequence
   a_one_wait: assert property (s_req |=> s_ans)
      else $error("bus answer late");
   a_flag_only: assert property (avs_read && !avs_waitrequest && avs_address == 8'h2c
      |-> avs_readdata[31:8] == 24'h0 && avs_readdata[6:0] == 7'h00)
      else $error("control read shows write-only bits");
   a_vector_fixed: assert property (restart_pulse |-> restart_vector == 16'h000c)
      else $error("restart vector wrong");
   a_pulse_single: assert property (restart_pulse |=> !restart_pulse)
      else $error("restart pulse too long");
   a_stop_taken: assert property (stop_req && !stopped && !$past(stopped) |=> stopped)
      else $error("stop not entered");
   a_stop_quiet: assert property (stopped && $past(stopped) |-> !sys_tick && !timer_tick)
      else $error("tick while stopped");
   a_halt_quiet: assert property (halt_req && $past(halt_req) |-> !sys_tick)
      else $error("system tick in halt");
   a_restart_cause: assert property (restart_pulse |-> $past(stopped, 2) && !$past(stopped))
      else $error("restart without stop");
endmodule

bind srcd_top srcd_chk u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .stop_req(stop_req), .halt_req(halt_req),
   .stopped(stopped), .restart_pulse(restart_pulse), .restart_vector(restart_vector),
   .sys_tick(sys_tick), .timer_tick(timer_tick));

// file: verif/tb_srcd_top.sv
/* self-checking bench for srcd_top: bus accesses, tick rates, stop and wake.
   assumes the checker is bound separately; byte lanes always all enabled. */
`timescale 1ns/1ps
module tb_srcd_top;
   // ****************************************
   // stimulus and wiring
   // ****************************************
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic [7:0]  wake_pin = 8'hff;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic        stop_req = 1'b0;
   logic        halt_req = 1'b0;
   logic        spi_match = 1'b0;
   logic        wdt_timeout = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] q;
   wire  [31:0] avs_readdata;
   wire  [15:0] restart_vector;
   wire         avs_waitrequest, stopped, restart_pulse, sys_tick, timer_tick, irq;
   int          n_fail = 0, samples_checked = 0, cyc = 0, n, s, t;
   logic [7:0]  cv [4] = '{8'h00, 8'h02, 8'h01, 8'h03};
   int          es [4] = '{32, 64, 2, 4};

   srcd_top dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .stop_req(stop_req), .halt_req(halt_req), .wake_pin(wake_pin),
      .spi_match(spi_match), .wdt_timeout(wdt_timeout), .stopped(stopped),
      .restart_pulse(restart_pulse), .restart_vector(restart_vector),
      .sys_tick(sys_tick), .timer_tick(timer_tick), .irq(irq));

   always #25 clk = ~clk;
   // run is ~2750 cycles; ceiling leaves margin for the 2000-cycle delay
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   task finish_test();
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // request stands until waitrequest is seen low at a rising edge
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      acc(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask

   task cnt(input int len);
      s = 0;
      t = 0;
      repeat (len) begin
         @(posedge clk);
         s += sys_tick;
         t += timer_tick;
      end
   endtask

   // stop, check no early wake, then apply the wake cause and time it
   task srun(input logic [7:0] c, input logic [7:0] pi, input logic [7:0] pw,
             input logic [1:0] w);
      wake_pin <= pi;
      acc(1'b1, 8'h2c, {24'h0, c});
      @(posedge clk);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (20) @(posedge clk);
      chk("stopped", stopped, 1);
      wake_pin <= pw;
      wdt_timeout <= w[0];
      spi_match <= w[1];
      n = 0;
      while (restart_pulse !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      wdt_timeout <= 1'b0;
      spi_match <= 1'b0;
      wake_pin <= 8'hff;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      cnt(64);
      chk("reset_sys", s, 32);
      chk("reset_timer", t, 32);
      rd(8'h2c, 32'h0, "ctrl_reset");
      acc(1'b1, 8'h2c, 32'hff);
      rd(8'h2c, 32'h0, "ctrl_flag_kept");
      rd(8'h80, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 8'h2c, {24'h0, cv[i]});
         repeat (40) @(posedge clk);
         cnt(64);
         chk("sys_ticks", s, es[i]);
         chk("timer_ticks", t, es[i]);
      end
      halt_req <= 1'b1;
      @(posedge clk);
      cnt(64);
      chk("halt_sys", s, 0);
      chk("halt_timer", t, 4);
      rd(8'h38, 32'h11, "state_halt");
      halt_req <= 1'b0;
      acc(1'b1, 8'h34, 32'h3);
      srun(8'h00, 8'hff, 8'hff, 2'b01);
      chk("wdt_wake", n < 10, 1);
      rd(8'h2c, 32'h80, "flag_set");
      chk("irq_on", irq, 1);
      rd(8'h30, 32'h3, "status");
      acc(1'b1, 8'h30, 32'h3);
      repeat (3) @(posedge clk);
      chk("irq_off", irq, 0);
      srun(8'h4c, 8'hf7, 8'hff, 2'b00);
      chk("pin_high_wake", n < 10, 1);
      srun(8'h08, 8'hff, 8'hfb, 2'b00);
      chk("pin_low_wake", n < 10, 1);
      srun(8'h00, 8'hff, 8'hff, 2'b10);
      chk("spi_wake", n < 10, 1);
      srun(8'h20, 8'hff, 8'hff, 2'b01);
      chk("delay_len", n >= 2000 && n < 2100, 1);
      chk("vector", restart_vector, 32'h000c);
      rd(8'h2c, 32'h80, "flag_kept_on_write");
      finish_test();
   end
endmodule
